// File: sar_dmem.sv
// Single-port data memory for the process data areas.
// Assumes one clock; read data appear one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module sar_dmem #(
    parameter int DW = 16,
    parameter int DEPTH = 512,
    parameter int AW = 9
) (
    input wire logic ref_clk_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [DEPTH];

    // Write port and registered read
    always_ff @(posedge ref_clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end

endmodule
`default_nettype wire

// File: sar_pb_master.sv
// Fieldbus master model: sends address setting telegrams.
// Assumes the bench calls send and shares the block clock.
`timescale 1ns/1ps
`default_nettype none
module sar_pb_master
    import sar_pkg::*;
(
    input wire logic ref_clk_i,
    output sar_pkg::sar_ssa_t ssa_o
);
    initial ssa_o = '0;
    // One-cycle telegram launched off the falling edge, cleared after
    task automatic send(input logic [6:0] a, input logic [15:0] id,
        input logic lk);
        @(negedge ref_clk_i);
        ssa_o <= '{valid: 1'b1, addr: a, ident: id, lock: lk};
        @(negedge ref_clk_i);
        ssa_o <= '0;
    endtask
endmodule
`default_nettype wire

// File: sar_pkg.sv
// Package for the station address and register map block: register
// numbers, function and exception codes, data area tables and carriers.
// Assumes a Modbus RTU framer outside that hands over one parsed request.
package sar_pkg;

    // ------------------------------------------------------------------
    // Modbus function and exception codes
    // ------------------------------------------------------------------
    localparam logic [7:0] FN_RD_COIL = 8'h01;
    localparam logic [7:0] FN_RD_INPUT = 8'h02;
    localparam logic [7:0] FN_RD_HOLD = 8'h03;
    localparam logic [7:0] FN_WR_COIL = 8'h05;
    localparam logic [7:0] FN_WR_HOLD = 8'h06;
    localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
    localparam logic [15:0] COIL_ON = 16'hFF00;
    localparam logic [15:0] COIL_OFF = 16'h0000;

    // ------------------------------------------------------------------
    // Register numbers (1-based, up to 0x10000)
    // ------------------------------------------------------------------
    localparam int REG_NUM_W = 17;
    localparam logic [16:0] REG_OP_MODE = 17'h00001;
    localparam logic [16:0] REG_CUR_ADDR = 17'h0400C;
    localparam logic [16:0] REG_CFG_ADDR = 17'h0400D;
    localparam logic [16:0] REG_BITRATE = 17'h0400F;
    localparam logic [16:0] REG_SRC_HI = 17'h04011;
    localparam logic [16:0] REG_SRC_LO = 17'h04012;
    localparam logic [16:0] REG_LOCK = 17'h04102;

    // ------------------------------------------------------------------
    // Field values and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] OP_RUN = 16'h0001;
    localparam logic [15:0] OP_FACTORY = 16'h0002;
    localparam logic [15:0] OP_RESET = 16'h0003;
    localparam logic [15:0] SRC_MEMREG = 16'h0000;
    localparam logic [15:0] SRC_SWITCH = 16'h0001;
    localparam logic [15:0] SRC_SSA = 16'h0002;
    localparam logic [6:0] ADDR_DEFAULT = 7'h7E;
    localparam logic [7:0] ADDR_MAX_FIXED = 8'h7D;
    localparam logic [15:0] RST_OP_MODE = 16'h0000;
    localparam logic [7:0] RST_CFG_ADDR = 8'h7E;
    localparam logic [31:0] RST_SRC = 32'h0000_0000;
    localparam int BITRATE_W = 4;
    localparam logic [3:0] RST_BITRATE = 4'h0;

    // ------------------------------------------------------------------
    // Data areas: coil ranges first, then register ranges
    // ------------------------------------------------------------------
    localparam int MEM_AW = 9;
    localparam int MEM_DEPTH = 512;
    localparam int N_AREA = 6;
    localparam logic [16:0] AREA_LO [N_AREA] = '{17'h00001, 17'h02001,
        17'h08001, 17'h01001, 17'h01401, 17'h02001};
    localparam logic [16:0] AREA_HI [N_AREA] = '{17'h00800, 17'h03000,
        17'h08800, 17'h01080, 17'h01500, 17'h02080};
    localparam logic [8:0] AREA_BASE [N_AREA] = '{9'h000, 9'h080, 9'h180,
        9'h000, 9'h080, 9'h180};
    localparam logic AREA_COIL [N_AREA] = '{1'b1, 1'b1, 1'b1,
        1'b0, 1'b0, 1'b0};

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [7:0] func;
        logic [16:0] addr;
        logic [15:0] data;
    } sar_mb_req_t;

    typedef struct packed {
        logic valid;
        logic exc;
        logic [15:0] data;
    } sar_mb_rsp_t;

    typedef struct packed {
        logic valid;
        logic [6:0] addr;
        logic [15:0] ident;
        logic lock;
    } sar_ssa_t;

    typedef enum logic {ST_IDLE, ST_MEM} sar_state_t;

endpackage

// File: sar_regbank.sv
// Register bank of the fieldbus slave: station address selection,
// bitrate report and the 16-bit Modbus register space with coil access.
// Assumes a Modbus RTU framer delivering parsed requests on ref_clk_i,
// fieldbus logic delivering address setting telegrams on the same clock.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Address source setting picks which stored station address is used.
// - Source zero takes the address from the configured address register.
// - Configured address 126 means default 126 and telegram assignment.
// - Telegram changes address only at 126 with a matching identity.
// - A telegram lock request is stored in the lock register until a factory reset.
// - Lock blocks telegram changes only; switches still change address.
// - Source 2 or configured address above 125 enables master assignment.
// - Under master assignment all other address sources are ignored.
// - Bitrate follows the master and is shown in a read-only register.
// - Configuration takes effect only at reset or at any accepted write to the mode register (values above 3 are refused).
// - Every register is 16 bits wide.
// - Register numbers run from 1 to 65536; few are implemented.
// - 8-bit values use the low byte; 32-bit values use two registers.
// - Register words hold their low byte in bits 7 to 0.
// - Coil read, input read and single coil write reach the data areas.
// - Coils map to register bits in ascending order from bit 0.
// - Data areas sit at fixed register and coil ranges.
// - Writing the reset code to the mode register resets the device.
module sar_regbank #(
    parameter logic [15:0] IDENT_NUM = 16'h5A3C  // Arbitrary identity value
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire sar_pkg::sar_mb_req_t mb_req_i,
    output logic mb_ready_o,
    output sar_pkg::sar_mb_rsp_t mb_rsp_o,
    input wire sar_pkg::sar_ssa_t ssa_i,
    input wire logic [6:0] switch_addr_i,
    input wire logic [3:0] rate_code_i,
    input wire logic lock_nv_i,
    output logic [6:0] station_addr_o,
    output logic auto_assign_o,
    output logic addr_lock_o,
    output logic lock_store_o,
    output logic module_reset_o,
    output logic factory_reset_o
);
    import sar_pkg::*;

    sar_state_t state;
    logic take;
    logic is_coil;
    logic func_ok;
    logic dec_mem;
    logic [8:0] dec_word;
    logic [3:0] dec_bit;
    logic [16:0] off;
    logic [8:0] word_q;
    logic [3:0] bit_q;
    logic [7:0] func_q;
    logic [15:0] data_q;
    logic mem_we;
    logic [8:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic [15:0] op_mode;
    logic [7:0] cfg_addr;
    logic [31:0] cfg_src;
    logic [15:0] act_src;
    logic [BITRATE_W-1:0] bitrate;
    logic apply_q;
    logic boot_q;
    logic next_auto;
    logic [6:0] sw_s1;
    logic [6:0] sw_s2;
    logic [3:0] rate_s1;
    logic [3:0] rate_s2;
    logic [3:0] rate_prev;
    logic reg_hit;
    logic reg_ro;
    logic op_bad;
    logic reg_wr;
    logic [15:0] reg_rdata;

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------

    // Only the master starts a transfer; this end only answers
    assign take = mb_req_i.valid && mb_ready_o;
    assign is_coil = (mb_req_i.func == FN_RD_COIL) ||
                     (mb_req_i.func == FN_RD_INPUT) ||
                     (mb_req_i.func == FN_WR_COIL);
    assign func_ok = is_coil || (mb_req_i.func == FN_RD_HOLD) ||
                     (mb_req_i.func == FN_WR_HOLD);
    assign op_bad = (mb_req_i.addr == REG_OP_MODE) &&
                    (mb_req_i.data > OP_RESET);
    assign reg_wr = take && (mb_req_i.func == FN_WR_HOLD) && reg_hit &&
                    !reg_ro && !op_bad;
    assign next_auto = (cfg_src[15:0] == SRC_SSA) ||
                       (cfg_addr > ADDR_MAX_FIXED);

    // Data area lookup: coil number or register number to word and bit
    always_comb begin
        dec_mem = 1'b0;
        dec_word = 9'h000;
        dec_bit = 4'h0;
        off = 17'h00000;
        for (int i = 0; i < N_AREA; i++) begin
            if ((AREA_COIL[i] == is_coil) && (mb_req_i.addr >= AREA_LO[i]) &&
                (mb_req_i.addr <= AREA_HI[i])) begin
                dec_mem = 1'b1;
                off = mb_req_i.addr - AREA_LO[i];
                if (is_coil) begin
                    dec_word = AREA_BASE[i] + off[12:4];
                    dec_bit = off[3:0];
                end else begin
                    dec_word = AREA_BASE[i] + off[8:0];
                end
            end
        end
    end

    // Configuration register read mux, 16-bit words
    always_comb begin
        reg_hit = 1'b1;
        reg_ro = 1'b0;
        reg_rdata = 16'h0000;
        case (mb_req_i.addr)
            REG_OP_MODE: reg_rdata = op_mode;
            REG_CUR_ADDR: begin
                reg_rdata = {9'h000, station_addr_o};
                reg_ro = 1'b1;
            end
            REG_CFG_ADDR: reg_rdata = {8'h00, cfg_addr};
            REG_BITRATE: begin
                reg_rdata = {12'h000, bitrate};
                reg_ro = 1'b1;
            end
            REG_SRC_HI: reg_rdata = cfg_src[31:16];
            REG_SRC_LO: reg_rdata = cfg_src[15:0];
            REG_LOCK: begin
                reg_rdata = {15'h0000, addr_lock_o};
                reg_ro = 1'b1;
            end
            default: reg_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Transaction sequencer and response
    // ------------------------------------------------------------------

    // One request at a time; data area reads wait one cycle for memory
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
            mb_ready_o <= 1'b1;
            mb_rsp_o <= '0;
            func_q <= 8'h00;
            word_q <= 9'h000;
            bit_q <= 4'h0;
            data_q <= 16'h0000;
        end else begin
            mb_rsp_o.valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        func_q <= mb_req_i.func;
                        word_q <= dec_word;
                        bit_q <= dec_bit;
                        data_q <= mb_req_i.data;
                        if (!func_ok) begin
                            mb_rsp_o <= '{1'b1, 1'b1, {8'h00, EXC_ILL_FUNC}};
                        end else if ((mb_req_i.func == FN_WR_COIL) &&
                                     (mb_req_i.data != COIL_ON) &&
                                     (mb_req_i.data != COIL_OFF)) begin
                            mb_rsp_o <= '{1'b1, 1'b1, {8'h00, EXC_ILL_VALUE}};
                        end else if (dec_mem &&
                                     (mb_req_i.func != FN_WR_HOLD)) begin
                            state <= ST_MEM;
                            mb_ready_o <= 1'b0;
                        end else if (dec_mem) begin
                            mb_rsp_o <= '{1'b1, 1'b0, mb_req_i.data};
                        end else if (is_coil || !reg_hit ||
                                     ((mb_req_i.func == FN_WR_HOLD) &&
                                      reg_ro)) begin
                            mb_rsp_o <= '{1'b1, 1'b1, {8'h00, EXC_ILL_ADDR}};
                        end else if ((mb_req_i.func == FN_WR_HOLD) &&
                                     op_bad) begin
                            mb_rsp_o <= '{1'b1, 1'b1, {8'h00, EXC_ILL_VALUE}};
                        end else if (mb_req_i.func == FN_RD_HOLD) begin
                            mb_rsp_o <= '{1'b1, 1'b0, reg_rdata};
                        end else begin
                            mb_rsp_o <= '{1'b1, 1'b0, mb_req_i.data};
                        end
                    end
                end
                ST_MEM: begin
                    state <= ST_IDLE;
                    mb_ready_o <= 1'b1;
                    mb_rsp_o.valid <= 1'b1;
                    mb_rsp_o.exc <= 1'b0;
                    if (func_q == FN_WR_COIL) begin
                        mb_rsp_o.data <= data_q;
                    end else if (func_q == FN_RD_HOLD) begin
                        mb_rsp_o.data <= mem_rdata;
                    end else begin
                        mb_rsp_o.data <= {15'h0000, mem_rdata[bit_q]};
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    mb_ready_o <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Data memory
    // ------------------------------------------------------------------

    // Holding writes go straight in; coil writes read, patch one bit, write
    always_comb begin
        mem_we = 1'b0;
        mem_addr = dec_word;
        mem_wdata = mb_req_i.data;  // Low byte in bits 7:0
        if (state == ST_MEM) begin
            mem_addr = word_q;
            if (func_q == FN_WR_COIL) begin
                mem_we = 1'b1;
                mem_wdata = mem_rdata;
                mem_wdata[bit_q] = (data_q == COIL_ON);
            end
        end else if (take && dec_mem && (mb_req_i.func == FN_WR_HOLD)) begin
            mem_we = 1'b1;
        end
    end

    sar_dmem #(
        .DW(16),
        .DEPTH(MEM_DEPTH),
        .AW(MEM_AW)
    ) u_dmem (
        .ref_clk_i(ref_clk_i),
        .we_i(mem_we),
        .addr_i(mem_addr),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rdata)
    );

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------

    // Stored settings; mode writes schedule an apply cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            op_mode <= RST_OP_MODE;
            cfg_addr <= RST_CFG_ADDR;
            cfg_src <= RST_SRC;
            apply_q <= 1'b1;
            module_reset_o <= 1'b0;
            factory_reset_o <= 1'b0;
        end else begin
            apply_q <= 1'b0;
            module_reset_o <= 1'b0;
            factory_reset_o <= 1'b0;
            if (reg_wr) begin
                case (mb_req_i.addr)
                    REG_OP_MODE: begin
                        apply_q <= 1'b1;
                        op_mode <= (mb_req_i.data > OP_RUN) ?
                                   RST_OP_MODE : mb_req_i.data;
                        module_reset_o <= (mb_req_i.data == OP_RESET);
                        if (mb_req_i.data == OP_FACTORY) begin
                            factory_reset_o <= 1'b1;
                            cfg_addr <= RST_CFG_ADDR;
                            cfg_src <= RST_SRC;
                        end
                    end
                    REG_CFG_ADDR: cfg_addr <= mb_req_i.data[7:0];
                    REG_SRC_HI: cfg_src[31:16] <= mb_req_i.data;
                    REG_SRC_LO: cfg_src[15:0] <= mb_req_i.data;
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin synchronisers and bitrate report
    // ------------------------------------------------------------------

    // Two flops on the switch and rate pins; rate taken once stable
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sw_s1 <= 7'h00;
            sw_s2 <= 7'h00;
            rate_s1 <= RST_BITRATE;
            rate_s2 <= RST_BITRATE;
            rate_prev <= RST_BITRATE;
            bitrate <= RST_BITRATE;
        end else begin
            sw_s1 <= switch_addr_i;
            sw_s2 <= sw_s1;
            rate_s1 <= rate_code_i;
            rate_s2 <= rate_s1;
            rate_prev <= rate_s2;
            if (rate_s2 == rate_prev) begin
                bitrate <= rate_s2;
            end
        end
    end

    // ------------------------------------------------------------------
    // Station address selection
    // ------------------------------------------------------------------

    // Apply settings, then follow telegrams or switches per active source
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            boot_q <= 1'b1;
            act_src <= SRC_MEMREG;
            station_addr_o <= ADDR_DEFAULT;
            auto_assign_o <= 1'b1;
            addr_lock_o <= 1'b0;
            lock_store_o <= 1'b0;
        end else begin
            lock_store_o <= 1'b0;
            if (apply_q) begin
                boot_q <= 1'b0;
                act_src <= cfg_src[15:0];
                auto_assign_o <= next_auto;
                if (factory_reset_o) begin
                    addr_lock_o <= 1'b0;
                end else if (boot_q) begin
                    addr_lock_o <= lock_nv_i;  // Restore stored lock
                end
                if (next_auto) begin
                    station_addr_o <= ADDR_DEFAULT;
                end else if (cfg_src[15:0] == SRC_SWITCH) begin
                    station_addr_o <= sw_s2;
                end else begin
                    station_addr_o <= cfg_addr[6:0];
                end
            end else if (auto_assign_o) begin
                // Other sources ignored here; master telegrams go to 126
                if (ssa_i.valid && (station_addr_o == ADDR_DEFAULT) &&
                    (ssa_i.ident == IDENT_NUM) && !addr_lock_o) begin
                    station_addr_o <= ssa_i.addr;
                    if (ssa_i.lock) begin
                        addr_lock_o <= 1'b1;
                        lock_store_o <= 1'b1;
                    end
                end
            end else if (act_src == SRC_SWITCH) begin
                station_addr_o <= sw_s2;  // Lock does not apply
            end
        end
    end

endmodule
`default_nettype wire

// File: sar_regbank_asserts.sv
// Checker for the register bank, watching the top module ports only.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module sar_regbank_asserts
    import sar_pkg::*;
#(
    parameter logic [15:0] IDENT_NUM = 16'h5A3C
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire sar_pkg::sar_mb_req_t mb_req_i,
    input wire logic mb_ready_o,
    input wire sar_pkg::sar_mb_rsp_t mb_rsp_o,
    input wire sar_pkg::sar_ssa_t ssa_i,
    input wire logic [6:0] station_addr_o,
    input wire logic auto_assign_o,
    input wire logic addr_lock_o,
    input wire logic lock_store_o,
    input wire logic module_reset_o
);
    // ------------------------------------------------------------
    // Request and telegram qualifiers
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic ssa_ok;
    logic [7:0] fn;
    assign take = mb_req_i.valid && mb_ready_o;
    assign fn = mb_req_i.func;
    assign ssa_ok = ssa_i.valid && auto_assign_o && !addr_lock_o
        && station_addr_o == ADDR_DEFAULT && ssa_i.ident == IDENT_NUM;

    mem_timing_a: assert property (take && fn == FN_RD_HOLD
        && mb_req_i.addr == 17'h01001 |=> !mb_ready_o ##1
        (mb_rsp_o.valid && mb_ready_o)) else $error("memory read timing");
    cfg_byte_a: assert property (take && fn == FN_RD_HOLD
        && mb_req_i.addr == REG_CFG_ADDR |=> mb_rsp_o.valid
        && mb_rsp_o.data[15:8] == 8'h00) else $error("config high byte");
    ro_refuse_a: assert property (take && fn == FN_WR_HOLD
        && mb_req_i.addr == REG_BITRATE |=> mb_rsp_o.exc
        && mb_rsp_o.data[7:0] == EXC_ILL_ADDR) else $error("RO write taken");
    unmapped_reg_a: assert property (take && fn == FN_RD_HOLD
        && mb_req_i.addr == 17'h00100 |=> mb_rsp_o.valid && mb_rsp_o.exc
        && mb_rsp_o.data[7:0] == EXC_ILL_ADDR) else $error("unmapped read");
    ssa_apply_a: assert property (ssa_ok
        |=> station_addr_o == $past(ssa_i.addr)) else $error("ssa addr");
    ssa_lock_a: assert property (ssa_ok && ssa_i.lock
        |=> addr_lock_o && lock_store_o) else $error("ssa lock");
    store_pulse_a: assert property (lock_store_o
        |=> !lock_store_o) else $error("lock store pulse");
    mode_reset_a: assert property (take && fn == FN_WR_HOLD
        && mb_req_i.addr == REG_OP_MODE && mb_req_i.data == OP_RESET
        |=> module_reset_o ##1 !module_reset_o) else $error("mode reset");

    cover property (ssa_ok && ssa_i.lock);
    cover property (take && fn == FN_WR_COIL);
    cover property (module_reset_o);
endmodule

bind sar_regbank sar_regbank_asserts #(.IDENT_NUM(IDENT_NUM)) u_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .mb_req_i(mb_req_i),
    .mb_ready_o(mb_ready_o), .mb_rsp_o(mb_rsp_o), .ssa_i(ssa_i),
    .station_addr_o(station_addr_o), .auto_assign_o(auto_assign_o),
    .addr_lock_o(addr_lock_o), .lock_store_o(lock_store_o),
    .module_reset_o(module_reset_o));
`default_nettype wire

// File: sar_regbank_tb_top.sv
// Testbench for the register bank, acting as the Modbus master.
// Assumes the fieldbus master model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module sar_regbank_tb_top;
    import sar_pkg::*;
    localparam logic [15:0] ident_val = 16'h1234; // Arbitrary identity
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    sar_mb_req_t mb_req = '0;
    sar_mb_rsp_t rsp;
    sar_mb_rsp_t last;
    sar_ssa_t ssa;
    logic mb_ready;
    logic [6:0] sw = 7'h21;
    logic [3:0] rate = 4'h5;
    logic [6:0] station;
    logic auto_on, lock_on, lock_st, mod_rst, fac_rst;
    logic rst_seen = 1'b0;
    logic fac_seen = 1'b0;
    logic lock_nv = 1'b0;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;

    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    sar_regbank #(.IDENT_NUM(ident_val)) u_sar_regbank (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .mb_req_i(mb_req),
        .mb_ready_o(mb_ready), .mb_rsp_o(rsp), .ssa_i(ssa),
        .switch_addr_i(sw), .rate_code_i(rate), .lock_nv_i(lock_nv),
        .station_addr_o(station), .auto_assign_o(auto_on),
        .addr_lock_o(lock_on), .lock_store_o(lock_st),
        .module_reset_o(mod_rst), .factory_reset_o(fac_rst));
    sar_pb_master u_sar_pb_master (.ref_clk_i(ref_clk_i), .ssa_o(ssa));

    // Cycle ceiling and reset pulse monitor
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (mod_rst === 1'b1) rst_seen <= 1'b1;
        if (fac_rst === 1'b1) fac_seen <= 1'b1;
        if (cyc == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [16:0] e,
        input logic [16:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One Modbus request, held until taken, answer caught within 4 cycles
    task automatic xfer(input logic [7:0] f, input logic [16:0] a,
        input logic [15:0] d, input logic x, input logic [15:0] e,
        input string nm);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        while (mb_ready !== 1'b1) @(negedge ref_clk_i);
        mb_req <= '{valid: 1'b1, func: f, addr: a, data: d};
        @(negedge ref_clk_i);
        mb_req <= '0;
        while (rsp.valid !== 1'b1 && n < 4) begin
            @(negedge ref_clk_i);
            n++;
        end
        last = rsp;
        if (rsp.valid !== 1'b1) last.exc = ~x;
        chk(nm, {x, e}, {last.exc, last.data});
    endtask

    task automatic wait_st(input logic [6:0] e, input string nm);
        repeat (6) @(negedge ref_clk_i);
        chk(nm, {10'h0, e}, {10'h0, station});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(negedge ref_clk_i);
        rst_i <= 1'b0;
        wait_st(7'h7E, "reset station");
        chk("auto", 17'h1, {16'h0, auto_on});
        xfer(FN_RD_HOLD, REG_CFG_ADDR, 16'h0, 1'b0, 16'h007E, "cfg");
        xfer(FN_RD_HOLD, REG_SRC_LO, 16'h0, 1'b0, 16'h0, "src");
        $display("test defaults done");
        u_sar_pb_master.send(7'h05, ~ident_val, 1'b1);
        wait_st(7'h7E, "foreign ident");
        u_sar_pb_master.send(7'h05, ident_val, 1'b1);
        wait_st(7'h05, "ssa station");
        xfer(FN_RD_HOLD, REG_LOCK, 16'h0, 1'b0, 16'h0001, "lock");
        $display("test telegram done");
        xfer(FN_WR_HOLD, REG_CFG_ADDR, 16'h000A, 1'b0, 16'h000A, "c");
        xfer(FN_WR_HOLD, REG_SRC_LO, 16'h1, 1'b0, 16'h1, "s");
        wait_st(7'h05, "no early apply");
        xfer(FN_WR_HOLD, REG_OP_MODE, 16'h1, 1'b0, 16'h1, "run");
        wait_st(7'h21, "switch station");
        sw <= 7'h33;
        wait_st(7'h33, "switch after lock");
        xfer(FN_WR_HOLD, REG_SRC_LO, 16'h0, 1'b0, 16'h0, "s");
        xfer(FN_WR_HOLD, REG_OP_MODE, 16'h0, 1'b0, 16'h0, "run");
        wait_st(7'h0A, "memreg station");
        xfer(FN_WR_HOLD, REG_SRC_LO, 16'h2, 1'b0, 16'h2, "s");
        xfer(FN_WR_HOLD, REG_OP_MODE, 16'h0, 1'b0, 16'h0, "run");
        sw <= 7'h55;
        wait_st(7'h7E, "settle");
        chk("auto src", 17'h1, {16'h0, auto_on});
        chk("switch ignored", 17'h0, {16'h0, station == 7'h55});
        $display("test address source done");
        xfer(FN_WR_HOLD, 17'h01001, 16'h0, 1'b0, 16'h0, "w0");
        xfer(FN_WR_HOLD, 17'h01002, 16'h0, 1'b0, 16'h0, "w1");
        xfer(FN_WR_HOLD, 17'h02001, 16'h0, 1'b0, 16'h0, "w2");
        xfer(FN_WR_COIL, 17'h00003, COIL_ON, 1'b0, COIL_ON, "c3");
        xfer(FN_WR_COIL, 17'h00011, COIL_ON, 1'b0, COIL_ON, "c11");
        xfer(FN_WR_COIL, 17'h08010, COIL_ON, 1'b0, COIL_ON, "co");
        xfer(FN_RD_HOLD, 17'h01001, 16'h0, 1'b0, 16'h0004, "bit2");
        xfer(FN_RD_HOLD, 17'h01002, 16'h0, 1'b0, 16'h0001, "bit0");
        xfer(FN_RD_HOLD, 17'h02001, 16'h0, 1'b0, 16'h8000, "b15");
        xfer(FN_RD_COIL, 17'h00003, 16'h1, 1'b0, 16'h0001, "rc");
        xfer(FN_RD_INPUT, 17'h00011, 16'h1, 1'b0, 16'h0001, "ri");
        xfer(FN_WR_COIL, 17'h00003, 16'h1234, 1'b1, 16'h0003, "cv");
        $display("test coils done");
        xfer(FN_RD_HOLD, 17'h00100, 16'h0, 1'b1, 16'h0002, "unm");
        xfer(FN_WR_HOLD, REG_BITRATE, 16'h1, 1'b1, 16'h0002, "ro");
        xfer(8'h10, REG_CFG_ADDR, 16'h0, 1'b1, 16'h0001, "fn");
        xfer(FN_RD_HOLD, REG_BITRATE, 16'h0, 1'b0, 16'h0005, "rate");
        xfer(FN_WR_HOLD, REG_OP_MODE, OP_RESET, 1'b0, OP_RESET, "m3");
        repeat (2) @(negedge ref_clk_i);
        chk("reset pulse", 17'h1, {16'h0, rst_seen});
        xfer(FN_RD_HOLD, REG_OP_MODE, 16'h0, 1'b0, 16'h0, "mode");
        lock_nv <= 1'b1;
        rst_i <= 1'b1;
        @(negedge ref_clk_i);
        rst_i <= 1'b0;
        wait_st(7'h7E, "reboot");
        chk("lock boot", 17'h1, {16'h0, lock_on});
        xfer(FN_WR_HOLD, REG_OP_MODE, 16'h2, 1'b0, 16'h2, "m2");
        wait_st(7'h7E, "factory station");
        chk("factory", 17'h2, {15'h0, fac_seen, lock_on});
        $display("test refusals done");
        print_verdict();
    end
endmodule
`default_nettype wire
